// File: cfgphy_map.vh
/*
  Register offsets, field positions, reset values and timing counts of
  the configuration and PHY register bank.
  Assumes byte offsets on the host parallel bus, 16-bit registers.
*/
`ifndef CFGPHY_MAP_VH
`define CFGPHY_MAP_VH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define CP_OFS_RSVD_LAST   8'h07
`define CP_OFS_STRAP_CFG   8'h08
`define CP_OFS_STA_LOW     8'h10
`define CP_OFS_STA_MID     8'h12
`define CP_OFS_STA_HIGH    8'h14
`define CP_OFS_PHY_CTRL    8'he4
`define CP_OFS_PHY_STAT    8'he6
`define CP_OFS_PHY_ID_LO   8'he8
`define CP_OFS_PHY_ID_HI   8'hea
`define CP_OFS_AN_ADV      8'hec
`define CP_OFS_AN_PARTNER  8'hee
`define CP_OFS_SPECIAL     8'hf4
`define CP_OFS_PORT_CTRL   8'hf6
`define CP_OFS_PORT_STAT   8'hf8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CP_RST_PHY_CTRL    16'h3120
`define CP_RST_PHY_STAT    16'h7808
`define CP_RST_AN_ADV      16'h05e1
`define CP_RST_AN_PARTNER  16'h0001
`define CP_RST_SPECIAL     16'h0000
`define CP_RST_PORT_CTRL   16'h00ff
`define CP_RST_PORT_STAT   16'h8080

// ----------------------------------------------------------------------
// Strap configuration bit positions
// ----------------------------------------------------------------------
`define CP_BIT_LITTLE_END  10
`define CP_BIT_EEPROM      9
`define CP_BIT_BUS8        7
`define CP_BIT_BUS16       6
`define CP_BIT_SHARED      4
`define CP_BIT_PKG48       1

// ----------------------------------------------------------------------
// Special control/status fields
// ----------------------------------------------------------------------
`define CP_SPC_CTRL_MASK   16'h00ff
`define CP_BIT_SPC_FAULT   8
`define CP_BIT_SPC_DONE    9

// ----------------------------------------------------------------------
// Timing and sequencing
// ----------------------------------------------------------------------
`define CP_STRAP_SETTLE    2'd3
`define CP_EE_FIRST_WORD   2'd1
`define CP_EE_LAST_WORD    2'd3

`endif

// File: cfgphy_reg_bank.v
/*
  Configuration register and upper PHY register bank behind the host
  parallel register port, with strap capture and station address load.
  Assumes: host strobes are synchronous to core_clk one-cycle pulses;
  strap pins are asynchronous and stable around reset release; the
  EEPROM reader answers one word per request.
*/
`timescale 1ns/1ps
`include "cfgphy_map.vh"

module cfgphy_reg_bank #(
  parameter [15:0] PHY_ID_LOW  = 16'h0a5c, // Arbitrary value
  parameter [15:0] PHY_ID_HIGH = 16'h00c3  // Arbitrary value
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Strap and bonding pins
  input  wire        eeprom_serial_clock_pin,
  input  wire        eeprom_data_pin,
  input  wire        port_led_strap_pin,
  input  wire        shared_bus_strap,
  input  wire        package_48pin,
  // Host register port
  input  wire [7:0]  host_addr,
  input  wire [1:0]  host_be,
  input  wire [15:0] host_wdata,
  input  wire        host_wr,
  input  wire        host_rd,
  output reg  [15:0] host_rdata,
  output reg         host_rvalid,
  // PHY status sources
  input  wire        phy_stat_upd,
  input  wire [15:0] phy_stat_in,
  input  wire        partner_upd,
  input  wire [15:0] partner_in,
  input  wire        port_stat_upd,
  input  wire [15:0] port_stat_in,
  input  wire        cable_fault_evt,
  input  wire        diag_done_evt,
  // PHY control outputs
  output wire [15:0] phy_ctrl_out,
  output wire [15:0] an_adv_out,
  output wire [15:0] port_ctrl_out,
  output wire [7:0]  special_ctrl_out,
  // EEPROM word reader
  output reg         ee_req,
  output reg  [1:0]  ee_word_addr,
  input  wire        ee_ack,
  input  wire [15:0] ee_word,
  // Configuration and station address outputs
  output wire        straps_valid,
  output wire        bus8_mode,
  output wire [47:0] station_addr
);

  // --------------------------------------------------------------------
  // Local declarations
  // --------------------------------------------------------------------
  localparam [1:0] EE_IDLE = 2'd0;
  localparam [1:0] EE_REQ  = 2'd1;
  localparam [1:0] EE_WAIT = 2'd2;
  localparam [1:0] EE_DONE = 2'd3;

  reg  [2:0]  sck_sync_r;
  reg  [2:0]  eed_sync_r;
  reg  [2:0]  led_sync_r;
  reg  [2:0]  shr_sync_r;
  reg  [2:0]  pkg_sync_r;
  reg  [1:0]  settle_r;
  reg         latched_r;
  reg  [15:0] strap_cfg_r;

  reg  [15:0] phy_ctrl_r;
  reg  [15:0] phy_stat_r;
  reg  [15:0] an_adv_r;
  reg  [15:0] partner_r;
  reg  [15:0] special_r;
  reg  [15:0] port_ctrl_r;
  reg  [15:0] port_stat_r;
  reg  [15:0] sta_low_r;
  reg  [15:0] sta_mid_r;
  reg  [15:0] sta_high_r;
  reg  [1:0]  ee_state_r;

  reg  [15:0] rd_mux;
  wire [7:0]  word_addr;
  wire [1:0]  lane;
  wire [15:0] wdata_al;
  wire        ee_store;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Replace only the enabled byte lanes of a stored word.
  function [15:0] merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  be;
    begin
      merge[7:0]  = be[0] ? new_v[7:0]  : old_v[7:0];
      merge[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // A stable strap level: second and third stages agree.
  function stable;
    input [2:0] s;
    begin
      stable = (s[1] == s[2]);
    end
  endfunction

  // --------------------------------------------------------------------
  // Strap synchronisers and capture
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      sck_sync_r <= 3'h0;
      eed_sync_r <= 3'h0;
      led_sync_r <= 3'h0;
      shr_sync_r <= 3'h0;
      pkg_sync_r <= 3'h0;
    end else begin
      sck_sync_r <= {sck_sync_r[1:0], eeprom_serial_clock_pin};
      eed_sync_r <= {eed_sync_r[1:0], eeprom_data_pin};
      led_sync_r <= {led_sync_r[1:0], port_led_strap_pin};
      shr_sync_r <= {shr_sync_r[1:0], shared_bus_strap};
      pkg_sync_r <= {pkg_sync_r[1:0], package_48pin};
    end
  end

  // Capture waits until the pipes are full, then until all pins agree
  // across stages, so a pin still moving at release is not frozen.
  always @(posedge core_clk) begin
    if (rst) begin
      settle_r    <= 2'd0;
      latched_r   <= 1'b0;
      strap_cfg_r <= 16'h0000;
    end else if (!latched_r) begin
      if (settle_r != `CP_STRAP_SETTLE) begin
        settle_r <= settle_r + 2'd1;
      end else if (stable(sck_sync_r) && stable(eed_sync_r) &&
                   stable(led_sync_r) && stable(shr_sync_r) &&
                   stable(pkg_sync_r)) begin
        latched_r <= 1'b1;
        strap_cfg_r <= 16'h0000;
        strap_cfg_r[`CP_BIT_LITTLE_END] <= sck_sync_r[2];
        strap_cfg_r[`CP_BIT_EEPROM] <= eed_sync_r[2];
        strap_cfg_r[`CP_BIT_BUS8]   <= ~led_sync_r[2];
        strap_cfg_r[`CP_BIT_BUS16]  <= led_sync_r[2];
        strap_cfg_r[`CP_BIT_SHARED] <= shr_sync_r[2];
        strap_cfg_r[`CP_BIT_PKG48]  <= pkg_sync_r[2];
      end
    end
  end

  assign straps_valid = latched_r;
  assign bus8_mode    = strap_cfg_r[`CP_BIT_BUS8];

  // --------------------------------------------------------------------
  // Host address and lane steering
  // --------------------------------------------------------------------
  // Byte mode carries one byte on the low data lines; the odd offset
  // selects the upper half of the word.
  assign word_addr = {host_addr[7:1], 1'b0};
  assign lane      = bus8_mode ? (host_addr[0] ? 2'b10 : 2'b01)
                               : host_be;
  assign wdata_al  = bus8_mode ? {host_wdata[7:0], host_wdata[7:0]}
                               : host_wdata;

  // --------------------------------------------------------------------
  // Station address load from EEPROM
  // --------------------------------------------------------------------
  assign ee_store = (ee_state_r == EE_WAIT) && ee_ack;

  always @(posedge core_clk) begin
    if (rst) begin
      ee_state_r   <= EE_IDLE;
      ee_req       <= 1'b0;
      ee_word_addr <= `CP_EE_FIRST_WORD;
    end else begin
      ee_req <= 1'b0;
      case (ee_state_r)
        EE_IDLE: begin
          if (latched_r) begin
            ee_state_r <= strap_cfg_r[`CP_BIT_EEPROM] ? EE_REQ
                                                      : EE_DONE;
          end
        end
        EE_REQ: begin
          ee_req     <= 1'b1;
          ee_state_r <= EE_WAIT;
        end
        EE_WAIT: begin
          if (ee_ack) begin
            if (ee_word_addr == `CP_EE_LAST_WORD) begin
              ee_state_r <= EE_DONE;
            end else begin
              ee_word_addr <= ee_word_addr + 2'd1;
              ee_state_r   <= EE_REQ;
            end
          end
        end
        default: begin
          ee_state_r <= EE_DONE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------
  // Config writes have no path here; the strap word stays as captured.
  always @(posedge core_clk) begin
    if (rst) begin
      phy_ctrl_r  <= `CP_RST_PHY_CTRL;
      an_adv_r    <= `CP_RST_AN_ADV;
      port_ctrl_r <= `CP_RST_PORT_CTRL;
      sta_low_r   <= 16'h0000;
      sta_mid_r   <= 16'h0000;
      sta_high_r  <= 16'h0000;
    end else begin
      if (host_wr) begin
        case (word_addr)
          `CP_OFS_PHY_CTRL:
            phy_ctrl_r <= merge(phy_ctrl_r, wdata_al, lane);
          `CP_OFS_AN_ADV:
            an_adv_r <= merge(an_adv_r, wdata_al, lane);
          `CP_OFS_PORT_CTRL:
            port_ctrl_r <= merge(port_ctrl_r, wdata_al, lane);
          `CP_OFS_STA_LOW:
            sta_low_r <= merge(sta_low_r, wdata_al, lane);
          `CP_OFS_STA_MID:
            sta_mid_r <= merge(sta_mid_r, wdata_al, lane);
          `CP_OFS_STA_HIGH:
            sta_high_r <= merge(sta_high_r, wdata_al, lane);
          default: begin
          end
        endcase
      end
      // EEPROM word wins over a host write in the same cycle
      if (ee_store) begin
        case (ee_word_addr)
          2'd1:    sta_low_r  <= ee_word;
          2'd2:    sta_mid_r  <= ee_word;
          default: sta_high_r <= ee_word;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Status registers fed by the PHY
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      phy_stat_r  <= `CP_RST_PHY_STAT;
      partner_r   <= `CP_RST_AN_PARTNER;
      port_stat_r <= `CP_RST_PORT_STAT;
    end else begin
      if (phy_stat_upd)  phy_stat_r  <= phy_stat_in;
      if (partner_upd)   partner_r   <= partner_in;
      if (port_stat_upd) port_stat_r <= port_stat_in;
    end
  end

  // --------------------------------------------------------------------
  // Special control / cable diagnostic register
  // --------------------------------------------------------------------
  // Low byte is plain control; bit 8 clears on a written one, bit 9
  // clears on any write to the upper byte. A new event in the clear cycle survives.
  always @(posedge core_clk) begin
    if (rst) begin
      special_r <= `CP_RST_SPECIAL;
    end else begin
      if (host_wr && word_addr == `CP_OFS_SPECIAL) begin
        if (lane[0]) begin
          special_r[7:0] <= wdata_al[7:0];
        end
        if (lane[1] && wdata_al[`CP_BIT_SPC_FAULT]) begin
          special_r[`CP_BIT_SPC_FAULT] <= 1'b0;
        end
        if (lane[1]) begin
          special_r[`CP_BIT_SPC_DONE] <= 1'b0;
        end
      end
      if (cable_fault_evt) special_r[`CP_BIT_SPC_FAULT] <= 1'b1;
      if (diag_done_evt)   special_r[`CP_BIT_SPC_DONE]  <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Reserved and unmapped offsets return zero.
  always @* begin
    case (word_addr)
      `CP_OFS_STRAP_CFG:  rd_mux = strap_cfg_r;
      `CP_OFS_STA_LOW:    rd_mux = sta_low_r;
      `CP_OFS_STA_MID:    rd_mux = sta_mid_r;
      `CP_OFS_STA_HIGH:   rd_mux = sta_high_r;
      `CP_OFS_PHY_CTRL:   rd_mux = phy_ctrl_r;
      `CP_OFS_PHY_STAT:   rd_mux = phy_stat_r;
      `CP_OFS_PHY_ID_LO:  rd_mux = PHY_ID_LOW;
      `CP_OFS_PHY_ID_HI:  rd_mux = PHY_ID_HIGH;
      `CP_OFS_AN_ADV:     rd_mux = an_adv_r;
      `CP_OFS_AN_PARTNER: rd_mux = partner_r;
      `CP_OFS_SPECIAL:    rd_mux = special_r;
      `CP_OFS_PORT_CTRL:  rd_mux = port_ctrl_r;
      `CP_OFS_PORT_STAT:  rd_mux = port_stat_r;
      default:            rd_mux = 16'h0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        if (bus8_mode) begin
          host_rdata <= {8'h00, host_addr[0] ? rd_mux[15:8]
                                             : rd_mux[7:0]};
        end else begin
          host_rdata <= rd_mux;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign phy_ctrl_out     = phy_ctrl_r;
  assign an_adv_out       = an_adv_r;
  assign port_ctrl_out    = port_ctrl_r;
  assign special_ctrl_out = special_r[7:0];
  assign station_addr     = {sta_high_r, sta_mid_r, sta_low_r};

endmodule

// File: cfgphy_ee_model.sv
/*
  Behavioural EEPROM word reader answering the bank's load requests.
  Assumes one request outstanding at a time, on core_clk.
*/
`timescale 1ns/1ps
module cfgphy_ee_model #(
  parameter [15:0] W1 = 16'h0000,
  parameter [15:0] W2 = 16'h0000,
  parameter [15:0] W3 = 16'h0000
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Word request port
  input  wire        ee_req,
  input  wire [1:0]  ee_word_addr,
  output reg         ee_ack,
  output reg  [15:0] ee_word
);
  reg       busy_r;
  reg [3:0] wait_r;
  reg [1:0] idx_r;

  initial begin
    ee_ack  = 1'b0;
    ee_word = 16'h0000;
  end

  // Word 1 answers at once, later words stall to exercise slow replies
  always @(posedge core_clk) begin
    ee_ack  <= 1'b0;
    ee_word <= ~ee_word; // No stale word outside the ack cycle
    if (rst) begin
      busy_r <= 1'b0;
    end else if (ee_req) begin
      busy_r <= 1'b1;
      idx_r  <= ee_word_addr;
      wait_r <= {ee_word_addr, 2'b00} - 4'h4;
    end else if (busy_r) begin
      if (wait_r == 4'h0) begin
        busy_r  <= 1'b0;
        ee_ack  <= 1'b1;
        ee_word <= (idx_r == 2'd1) ? W1 :
                   (idx_r == 2'd2) ? W2 : W3;
      end else begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule

// File: cfgphy_reg_bank_monitor.sv
/*
  Concurrent checks on the register bank's ports.
  Assumes binding to cfgphy_reg_bank; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module cfgphy_reg_bank_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        port_led_strap_pin,
  input wire logic [7:0]  host_addr,
  input wire logic [1:0]  host_be,
  input wire logic [15:0] host_wdata,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic        host_rvalid,
  input wire logic [15:0] phy_ctrl_out,
  input wire logic [15:0] an_adv_out,
  input wire logic [15:0] port_ctrl_out,
  input wire logic [7:0]  special_ctrl_out,
  input wire logic        ee_req,
  input wire logic [1:0]  ee_word_addr,
  input wire logic        ee_ack,
  input wire logic        straps_valid,
  input wire logic        bus8_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence next_word_s;
    ##2 ee_req && ee_word_addr == $past(ee_word_addr, 2) + 2'd1;
  endsequence
  sequence load_quiet_s;
    !ee_req [*4];
  endsequence

  rd_answer_a: assert property (host_rd |=> host_rvalid)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (host_rvalid |-> $past(host_rd))
    else $error("read answer without a request");
  ee_order_a: assert property (
    ee_ack && ee_word_addr != 2'd3 |-> next_word_s)
    else $error("station words out of order");
  ee_stop_a: assert property (
    ee_ack && ee_word_addr == 2'd3 |=> load_quiet_s)
    else $error("request after last station word");
  reset_vals_a: assert property ($fell(rst) |-> phy_ctrl_out == 16'h3120 &&
    an_adv_out == 16'h05e1 && port_ctrl_out == 16'h00ff &&
    special_ctrl_out == 8'h00)
    else $error("control outputs not at reset values");
  strap_wait_a: assert property ($fell(rst) |-> !straps_valid [*3])
    else $error("straps captured too early");
  bus8_strap_a: assert property (
    straps_valid |-> bus8_mode == !port_led_strap_pin)
    else $error("bus width does not follow strap");
  special_wr_a: assert property (host_wr && host_addr == 8'hf4 &&
    (bus8_mode || host_be[0]) |=>
    special_ctrl_out == $past(host_wdata[7:0]))
    else $error("special control write lost");
  port_wr_a: assert property (host_wr && host_addr == 8'hf6 &&
    host_be == 2'b11 && !bus8_mode |=>
    port_ctrl_out == $past(host_wdata))
    else $error("port control write lost");
  port_hold_a: assert property (!host_wr |=> $stable(port_ctrl_out))
    else $error("port control changed without a write");
endmodule

// File: cfgphy_reg_bank_tb.sv
/*
  Self-checking bench for the register bank with an EEPROM reader model.
  Assumes the monitor and model files are compiled before this one.
*/
`timescale 1ns/1ps
module cfgphy_reg_bank_tb;
  localparam [15:0] W1 = 16'h1357, W2 = 16'h2468, W3 = 16'h9abc;
  localparam [15:0] ID_LO = 16'h5a0f; // Arbitrary value
  localparam [15:0] ID_HI = 16'h0c21; // Arbitrary value
  reg         core_clk = 1'b0, rst = 1'b1;
  reg         sk = 1'b0, ed = 1'b0, led = 1'b0, shr = 1'b0, pkg = 1'b0;
  reg  [7:0]  host_addr = 8'h00;
  reg  [1:0]  host_be = 2'b11;
  reg  [15:0] host_wdata = 16'h0000, ps = 16'h0000, pp = 16'h0000;
  reg  [15:0] pt = 16'h0000, cfg, d, c;
  reg         host_wr = 1'b0, host_rd = 1'b0, psu = 1'b0, ppu = 1'b0;
  reg         ptu = 1'b0, cfe = 1'b0, dde = 1'b0;
  wire [15:0] host_rdata, ee_word;
  wire [47:0] station_addr;
  wire        host_rvalid, ee_req, ee_ack, straps_valid;
  wire [1:0]  ee_word_addr;
  logic [15:0] expq[$];
  int         n_fail = 0, checks_done = 0, cyc = 0, n_req = 0, i;

  always #50 core_clk = ~core_clk;

  cfgphy_reg_bank #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI))
  u_cfgphy_reg_bank (
    .core_clk(core_clk), .rst(rst), .eeprom_serial_clock_pin(sk),
    .eeprom_data_pin(ed), .port_led_strap_pin(led),
    .shared_bus_strap(shr), .package_48pin(pkg), .host_addr(host_addr),
    .host_be(host_be), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .phy_stat_upd(psu), .phy_stat_in(ps), .partner_upd(ppu),
    .partner_in(pp), .port_stat_upd(ptu), .port_stat_in(pt),
    .cable_fault_evt(cfe), .diag_done_evt(dde), .phy_ctrl_out(),
    .an_adv_out(), .port_ctrl_out(), .special_ctrl_out(),
    .ee_req(ee_req), .ee_word_addr(ee_word_addr), .ee_ack(ee_ack),
    .ee_word(ee_word), .straps_valid(straps_valid), .bus8_mode(),
    .station_addr(station_addr));

  cfgphy_ee_model #(.W1(W1), .W2(W2), .W3(W3)) u_cfgphy_ee_model (
    .core_clk(core_clk), .rst(rst), .ee_req(ee_req),
    .ee_word_addr(ee_word_addr), .ee_ack(ee_ack), .ee_word(ee_word));

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("Checks %0d, errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Read answers sampled mid-cycle, well clear of the launching edge
  always @(negedge core_clk) begin
    if (host_rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        checks_done++;
        n_fail++;
        $display("Error %0t: read answer with no request", $time);
      end else chk(host_rdata, expq.pop_front());
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (ee_req === 1'b1) n_req++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict;
    end
  end

  // ----------------------------------------------------------------------
  // Host port drivers
  // ----------------------------------------------------------------------
  task rd(input [7:0] a, input [15:0] e);
    host_rd = 1'b1; host_wr = 1'b0; host_addr = a; expq.push_back(e);
    @(negedge core_clk);
  endtask
  task wr(input [7:0] a, input [1:0] be, input [15:0] v);
    host_wr = 1'b1; host_rd = 1'b0; host_addr = a; host_be = be;
    host_wdata = v;
    @(negedge core_clk);
  endtask
  task idle(input int n);
    host_wr = 1'b0; host_rd = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask
  task do_reset(input l, input e);
    rst = 1'b1; led = l; ed = e; sk = $urandom; shr = $urandom;
    pkg = $urandom;
    repeat (5) @(negedge core_clk);
    rst = 1'b0; n_req = 0;
    for (i = 0; i < 20 && straps_valid !== 1'b1; i++) @(negedge core_clk);
    cfg = {5'h00, sk, ed, 1'b0, ~l, l, 1'b0, shr, 2'b00, pkg, 1'b0};
    idle(40);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(93));
    @(negedge core_clk);
    do_reset(1'b1, 1'b1);
    chk(station_addr[15:0], W1);
    chk(station_addr[47:32], W3);
    rd(8'h08, cfg);
    rd(8'he4, 16'h3120);
    rd(8'he6, 16'h7808);
    rd(8'he8, ID_LO);
    rd(8'hea, ID_HI);
    rd(8'hec, 16'h05e1);
    rd(8'hee, 16'h0001);
    rd(8'hf4, 16'h0000);
    rd(8'hf6, 16'h00ff);
    rd(8'hf8, 16'h8080);
    for (i = 0; i < 8; i += 2) rd(i[7:0], 16'h0000);
    rd(8'h12, W2);
    d = $urandom; c = $urandom;
    wr(8'he4, 2'b11, d);
    rd(8'he4, d);
    wr(8'hec, 2'b01, c);
    rd(8'hec, {8'h05, c[7:0]});
    wr(8'hf6, 2'b11, c);
    rd(8'hf6, c);
    wr(8'h08, 2'b11, ~cfg);
    wr(8'he6, 2'b11, d);
    rd(8'h08, cfg);
    rd(8'he6, 16'h7808);
    ps = $urandom; pp = $urandom; pt = $urandom;
    idle(0); psu = 1'b1; ppu = 1'b1; ptu = 1'b1;
    idle(1); psu = 1'b0; ppu = 1'b0; ptu = 1'b0;
    rd(8'he6, ps);
    rd(8'hee, pp);
    rd(8'hf8, pt);
    wr(8'hf4, 2'b01, d);
    idle(0); cfe = 1'b1; dde = 1'b1;
    idle(1); cfe = 1'b0; dde = 1'b0;
    rd(8'hf4, {8'h03, d[7:0]});
    wr(8'hf4, 2'b10, 16'h0000);
    rd(8'hf4, {8'h01, d[7:0]});
    wr(8'hf4, 2'b10, 16'h0100);
    rd(8'hf4, {8'h00, d[7:0]});
    cfe = 1'b1;
    wr(8'hf4, 2'b10, 16'h0100);
    cfe = 1'b0;
    rd(8'hf4, {8'h01, d[7:0]});
    idle(3);
    do_reset(1'b0, 1'b0);
    chk(n_req[15:0], 16'h0000);
    rd(8'h08, {8'h00, cfg[7:0]});
    rd(8'h09, {8'h00, cfg[15:8]});
    rd(8'he5, 16'h0031);
    wr(8'he4, 2'b11, {8'h00, c[15:8]});
    wr(8'he5, 2'b11, {8'h00, d[7:0]});
    rd(8'he5, {8'h00, d[7:0]});
    rd(8'he4, {8'h00, c[15:8]});
    idle(3);
    chk(expq.size(), 16'h0000);
    print_verdict;
  end
endmodule

bind cfgphy_reg_bank cfgphy_reg_bank_monitor u_cfgphy_reg_bank_monitor (
  .core_clk(core_clk), .rst(rst), .port_led_strap_pin(port_led_strap_pin),
  .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
  .host_wr(host_wr), .host_rd(host_rd), .host_rvalid(host_rvalid),
  .phy_ctrl_out(phy_ctrl_out), .an_adv_out(an_adv_out),
  .port_ctrl_out(port_ctrl_out), .special_ctrl_out(special_ctrl_out),
  .ee_req(ee_req), .ee_word_addr(ee_word_addr), .ee_ack(ee_ack),
  .straps_valid(straps_valid), .bus8_mode(bus8_mode));
